/* tcc_pkg.sv */
//--------------------------------------------------------------------
// Notes on behaviour
//--------------------------------------------------------------------
// Notes on behaviour
// - 24-bit source address register per item
// - 24-bit destination address register per item
// - Normal mode: 16-bit count, ends at zero
// - Repeat/block: low byte counts, reloads from high
// - Block mode: block count ends at zero
// - Enable bits reset 0, route source here
// - Enable cleared on interrupt select or count end
// - Writing 1 to bit 7 starts software run
// - Software bit clearing follows interrupt select
// - Vector number 7 bits, address 0x0400 plus twice
// - Vector number writable only while bit 7 clear
// - Start by enabled request or software write
// - End clears source flag or enable bit
// - Processor mask and priorities never block activation
// - Simultaneous sources served in fixed priority
// - Interrupt select: every transfer or count end
// - Mode 00 normal, 01 repeat, 10 block
// - Size bit: 0 byte, 1 word
// - Chain enable skips end detection and clears
package tcc_pkg;

  //------------------------------------------------------------------
  // Register map (byte addresses)
  //------------------------------------------------------------------
  localparam logic [7:0] TCC_SRC_ADDR_OFS = 8'h00;
  localparam logic [7:0] TCC_DST_ADDR_OFS = 8'h04;
  localparam logic [7:0] TCC_CNT_A_OFS = 8'h08;
  localparam logic [7:0] TCC_CNT_B_OFS = 8'h0c;
  localparam logic [7:0] TCC_MODE_A_OFS = 8'h10;
  localparam logic [7:0] TCC_MODE_B_OFS = 8'h14;
  localparam logic [7:0] TCC_SW_VEC_OFS = 8'h18;
  localparam logic [7:0] TCC_STATUS_OFS = 8'h1c;
  localparam logic [7:0] TCC_ENABLE_OFS = 8'h20;

  //------------------------------------------------------------------
  // Field positions
  //------------------------------------------------------------------
  localparam int TCC_MA_SM_POS = 6;
  localparam int TCC_MA_DM_POS = 4;
  localparam int TCC_MA_MD_POS = 2;
  localparam int TCC_MA_SZ_POS = 0;
  localparam int TCC_MB_CHAIN_POS = 7;
  localparam int TCC_MB_PER_TRANSFER_INTERRUPT_SELECT_POS = 6;
  localparam int TCC_SWV_START_POS = 7;
  localparam int TCC_ST_BUSY_POS = 0;
  localparam int TCC_ST_SWEND_POS = 1;

  //------------------------------------------------------------------
  // Reset values and constants
  //------------------------------------------------------------------
  localparam logic [7:0] TCC_ENABLE_RST = 8'h00;
  localparam logic [7:0] TCC_SW_VEC_RST = 8'h00;
  localparam logic [15:0] TCC_VEC_BASE = 16'h0400;

  // Transfer mode field
  localparam logic [1:0] TCC_MD_NORMAL = 2'h0;
  localparam logic [1:0] TCC_MD_REPEAT = 2'h1;
  localparam logic [1:0] TCC_MD_BLOCK = 2'h2;

  typedef enum logic [1:0] {
    TCC_IDLE,
    TCC_XFER,
    TCC_SETTLE
  } tcc_state_t;

endpackage : tcc_pkg

/* tcc_core.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module tcc_core
  import tcc_pkg::*;
#(
  parameter int NBANK = 8,
  parameter int NSRC = 8 * NBANK,
  parameter int SRC_W = $clog2(NSRC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Interrupt sources and routing
  input wire logic [NSRC-1:0] src_req_i,
  output logic [NSRC-1:0] cpu_req_o,
  output logic [NSRC-1:0] src_clear_o,
  output logic sw_end_irq_o,
  // Bus transfer engine
  output logic xfer_req_o,
  output logic [23:0] xfer_src_addr_o,
  output logic [23:0] xfer_dst_addr_o,
  output logic xfer_word_o,
  input wire logic xfer_done_i,
  // Status
  output logic busy_o,
  output logic active_sw_o,
  output logic [SRC_W-1:0] active_src_o,
  output logic [15:0] sw_vector_addr_o
);

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  // Address step after one item: fixed, +size or -size
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                             input logic [1:0] m,
                                             input logic word);
    logic [23:0] sz;
    sz = word ? 24'h000002 : 24'h000001;
    if (!m[1]) begin
      return a;
    end else if (m[0]) begin
      return a - sz;
    end else begin
      return a + sz;
    end
  endfunction : step_addr

  // Lowest index wins
  function automatic logic [SRC_W-1:0] first_set(input logic [NSRC-1:0] v);
    logic [SRC_W-1:0] idx;
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  //------------------------------------------------------------------
  // Storage
  //------------------------------------------------------------------
  tcc_state_t state_ff;
  logic [23:0] src_addr_ff;
  logic [23:0] dst_addr_ff;
  logic [15:0] cnt_a_ff;
  logic [15:0] cnt_b_ff;
  logic [7:0] mode_a_ff;
  logic [7:0] mode_b_ff;
  logic [NSRC-1:0] enable_ff;
  logic sw_start_ff;
  logic [6:0] sw_vec_ff;
  logic sw_end_ff;
  logic active_sw_ff;
  logic [SRC_W-1:0] active_src_ff;
  logic [NSRC-1:0] src_clear_ff;
  logic [31:0] rdata_ff;

  logic [1:0] md;
  logic word_sz;
  logic chain;
  logic per_transfer_interrupt_select;
  logic [NSRC-1:0] pending;
  logic item_done;
  logic [15:0] nxt_cnt_a;
  logic [15:0] nxt_cnt_b;
  logic [7:0] low_dec;
  logic act_end;
  logic count_end;
  logic wr_mode_b;
  logic wr_bank;
  logic [7:0] bank_ofs;
  logic [SRC_W-1:0] bank_idx;

  assign md = mode_a_ff[TCC_MA_MD_POS +: 2];
  assign word_sz = mode_a_ff[TCC_MA_SZ_POS];
  assign chain = mode_b_ff[TCC_MB_CHAIN_POS];
  assign per_transfer_interrupt_select = mode_b_ff[TCC_MB_PER_TRANSFER_INTERRUPT_SELECT_POS];
  assign wr_mode_b = reg_wr_i && (reg_addr_i == TCC_MODE_B_OFS);
  assign bank_ofs = reg_addr_i - TCC_ENABLE_OFS;
  assign bank_idx = SRC_W'(bank_ofs[7:2]);
  assign wr_bank = reg_wr_i && (reg_addr_i >= TCC_ENABLE_OFS) &&
                   (bank_ofs[1:0] == 2'h0) && (bank_ofs[7:2] < NBANK);

  //------------------------------------------------------------------
  // Routing and activation requests
  //------------------------------------------------------------------
  // No mask input exists, so routed requests cannot be held off
  assign pending = src_req_i & enable_ff;
  assign cpu_req_o = src_req_i & ~enable_ff;
  assign item_done = (state_ff == TCC_XFER) && xfer_done_i;

  //------------------------------------------------------------------
  // Counter arithmetic for the item now finishing
  //------------------------------------------------------------------
  always_comb begin
    low_dec = cnt_a_ff[7:0] - 8'h01;
    nxt_cnt_a = cnt_a_ff;
    nxt_cnt_b = cnt_b_ff;
    act_end = 1'b1;
    count_end = 1'b0;
    unique case (md)
      TCC_MD_REPEAT: begin
        nxt_cnt_a[7:0] = (low_dec == 8'h00) ? cnt_a_ff[15:8] : low_dec;
      end
      TCC_MD_BLOCK: begin
        nxt_cnt_a[7:0] = (low_dec == 8'h00) ? cnt_a_ff[15:8] : low_dec;
        act_end = (low_dec == 8'h00);
        if (low_dec == 8'h00) begin
          nxt_cnt_b = cnt_b_ff - 16'h0001;
          count_end = (nxt_cnt_b == 16'h0000);
        end
      end
      default: begin
        // Prohibited mode 11 falls back to normal counting
        nxt_cnt_a = cnt_a_ff - 16'h0001;
        count_end = (nxt_cnt_a == 16'h0000);
      end
    endcase
    if (chain) begin
      count_end = 1'b0;
    end
  end

  //------------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------------
  // Settle gives the peripheral a cycle to drop its cleared flag
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= TCC_IDLE;
      active_sw_ff <= 1'b0;
      active_src_ff <= '0;
    end else begin
      unique case (state_ff)
        TCC_IDLE: begin
          // A raised end flag parks the start bit until it is cleared
          if (sw_start_ff && !sw_end_ff) begin
            state_ff <= TCC_XFER;
            active_sw_ff <= 1'b1;
          end else if (|pending) begin
            state_ff <= TCC_XFER;
            active_sw_ff <= 1'b0;
            active_src_ff <= first_set(pending);
          end
        end
        TCC_XFER: begin
          if (item_done && act_end) begin
            state_ff <= TCC_SETTLE;
          end
        end
        TCC_SETTLE: begin
          state_ff <= TCC_IDLE;
        end
      endcase
    end
  end

  //------------------------------------------------------------------
  // Address registers
  //------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_addr_ff <= 24'h000000;
      dst_addr_ff <= 24'h000000;
    end else if (item_done) begin
      src_addr_ff <= step_addr(src_addr_ff,
                               mode_a_ff[TCC_MA_SM_POS +: 2], word_sz);
      dst_addr_ff <= step_addr(dst_addr_ff,
                               mode_a_ff[TCC_MA_DM_POS +: 2], word_sz);
    end else if (reg_wr_i) begin
      if (reg_addr_i == TCC_SRC_ADDR_OFS) begin
        src_addr_ff <= reg_wdata_i[23:0];
      end
      if (reg_addr_i == TCC_DST_ADDR_OFS) begin
        dst_addr_ff <= reg_wdata_i[23:0];
      end
    end
  end

  //------------------------------------------------------------------
  // Count registers
  //------------------------------------------------------------------
  // Hardware update wins over a write in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_a_ff <= 16'h0000;
      cnt_b_ff <= 16'h0000;
    end else if (item_done) begin
      cnt_a_ff <= nxt_cnt_a;
      cnt_b_ff <= nxt_cnt_b;
    end else if (reg_wr_i) begin
      if (reg_addr_i == TCC_CNT_A_OFS) begin
        cnt_a_ff <= reg_wdata_i[15:0];
      end
      if (reg_addr_i == TCC_CNT_B_OFS) begin
        cnt_b_ff <= reg_wdata_i[15:0];
      end
    end
  end

  //------------------------------------------------------------------
  // Mode registers
  //------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_a_ff <= 8'h00;
      mode_b_ff <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == TCC_MODE_A_OFS) begin
        mode_a_ff <= reg_wdata_i[7:0];
      end
      if (wr_mode_b) begin
        mode_b_ff <= reg_wdata_i[7:0];
      end
    end
  end

  //------------------------------------------------------------------
  // Activation enable bits
  //------------------------------------------------------------------
  // Hardware clear is applied after a same-cycle bank write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_ff <= {NBANK{TCC_ENABLE_RST}};
    end else begin
      if (wr_bank) begin
        for (int b = 0; b < 8; b++) begin
          enable_ff[bank_idx * 8 + SRC_W'(b)] <= reg_wdata_i[b];
        end
      end
      if (item_done && act_end && !active_sw_ff && !chain &&
          (per_transfer_interrupt_select || count_end)) begin
        enable_ff[active_src_ff] <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------------
  // Source flag clear pulse
  //------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_clear_ff <= '0;
    end else begin
      src_clear_ff <= '0;
      if (item_done && act_end && !active_sw_ff && !chain &&
          !(per_transfer_interrupt_select || count_end)) begin
        src_clear_ff[active_src_ff] <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------------
  // Software vector and software end flag
  //------------------------------------------------------------------
  // The end flag set wins over the clearing write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_start_ff <= TCC_SW_VEC_RST[TCC_SWV_START_POS];
      sw_vec_ff <= TCC_SW_VEC_RST[6:0];
      sw_end_ff <= 1'b0;
    end else begin
      if (reg_wr_i && (reg_addr_i == TCC_SW_VEC_OFS)) begin
        if (!sw_start_ff) begin
          sw_vec_ff <= reg_wdata_i[6:0];
        end
        if (reg_wdata_i[TCC_SWV_START_POS]) begin
          sw_start_ff <= 1'b1;
        end
      end
      if (wr_mode_b && !reg_wdata_i[TCC_MB_PER_TRANSFER_INTERRUPT_SELECT_POS] && sw_end_ff) begin
        sw_start_ff <= 1'b0;
        sw_end_ff <= 1'b0;
      end
      if (item_done && act_end && active_sw_ff) begin
        if (!per_transfer_interrupt_select && !count_end) begin
          sw_start_ff <= 1'b0;
        end else begin
          sw_end_ff <= 1'b1;
        end
      end
    end
  end

  //------------------------------------------------------------------
  // Read port
  //------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= 32'h00000000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          TCC_SRC_ADDR_OFS: rdata_ff <= {8'h00, src_addr_ff};
          TCC_DST_ADDR_OFS: rdata_ff <= {8'h00, dst_addr_ff};
          TCC_CNT_A_OFS: rdata_ff <= {16'h0000, cnt_a_ff};
          TCC_CNT_B_OFS: rdata_ff <= {16'h0000, cnt_b_ff};
          TCC_MODE_A_OFS: rdata_ff <= {24'h000000, mode_a_ff};
          TCC_MODE_B_OFS: rdata_ff <= {24'h000000, mode_b_ff};
          TCC_SW_VEC_OFS: rdata_ff <= {24'h000000, sw_start_ff, sw_vec_ff};
          TCC_STATUS_OFS: begin
            rdata_ff[TCC_ST_BUSY_POS] <= (state_ff != TCC_IDLE);
            rdata_ff[TCC_ST_SWEND_POS] <= sw_end_ff;
          end
          default: begin
            if ((reg_addr_i >= TCC_ENABLE_OFS) &&
                (bank_ofs[1:0] == 2'h0) && (bank_ofs[7:2] < NBANK)) begin
              rdata_ff[7:0] <= enable_ff[bank_idx * 8 +: 8];
            end
          end
        endcase
      end
    end
  end

  //------------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------------
  assign reg_rdata_o = rdata_ff;
  assign src_clear_o = src_clear_ff;
  assign sw_end_irq_o = sw_end_ff;
  assign xfer_req_o = (state_ff == TCC_XFER);
  assign xfer_src_addr_o = src_addr_ff;
  assign xfer_dst_addr_o = dst_addr_ff;
  assign xfer_word_o = word_sz;
  assign busy_o = (state_ff != TCC_IDLE);
  assign active_sw_o = active_sw_ff;
  assign active_src_o = active_src_ff;
  assign sw_vector_addr_o = TCC_VEC_BASE + {8'h00, sw_vec_ff, 1'b0};

endmodule : tcc_core

/* tcc_engine_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bus engine and peripheral flag stand-in
// ----------------------------------------
module tcc_engine_model #(
  parameter int NSRC = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Bench control
  input wire logic [NSRC-1:0] raise_i,
  input wire logic [3:0] dly_i,
  // Block side
  input wire logic xfer_req_i,
  input wire logic [NSRC-1:0] clear_i,
  output logic [NSRC-1:0] flag_o,
  output logic done_o
);
  logic [3:0] wait_ff;

  // Flags hold until the block clears them; clear beats raise
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) flag_o <= '0;
    else flag_o <= (flag_o | raise_i) & ~clear_i;
  end

  // One item per done pulse, after dly_i wait cycles
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_ff <= 4'h0;
      done_o <= 1'b0;
    end else if (xfer_req_i && !done_o && wait_ff == dly_i) begin
      wait_ff <= 4'h0;
      done_o <= 1'b1;
    end else begin
      wait_ff <= (xfer_req_i && !done_o) ? wait_ff + 4'h1 : 4'h0;
      done_o <= 1'b0;
    end
  end
endmodule : tcc_engine_model

/* tcc_core_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the transfer controller
// ----------------------------------------
module tcc_core_props
  import tcc_pkg::*;
#(
  parameter int NSRC = 64
) (
  // Clock, reset, register port
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Sources and engine
  input wire logic [NSRC-1:0] src_req_i,
  input wire logic [NSRC-1:0] cpu_req_o,
  input wire logic [NSRC-1:0] src_clear_o,
  input wire logic sw_end_irq_o,
  input wire logic xfer_req_o,
  input wire logic [23:0] xfer_src_addr_o,
  input wire logic [23:0] xfer_dst_addr_o,
  input wire logic xfer_done_i,
  input wire logic busy_o,
  input wire logic [15:0] sw_vector_addr_o
);
  // Vector number as held behind the address output
  wire logic [6:0] vec_num = sw_vector_addr_o[7:1];

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  cpu_route_a: assert property ((cpu_req_o & ~src_req_i) == '0)
    else $error("processor request without a source flag");
  route_start_a: assert property (!busy_o &&
    |(src_req_i & ~cpu_req_o) |=> busy_o)
    else $error("routed request did not start an activation");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside the read answer cycle");
  settle_a: assert property ($past(resetn_i) && $fell(xfer_req_o)
    |-> busy_o ##1 !busy_o) else $error("end of activation not settled");
  clear_cause_a: assert property (|src_clear_o
    |-> $past(xfer_req_o && xfer_done_i)) else $error("stray flag clear");
  clear_single_a: assert property ($onehot0(src_clear_o))
    else $error("several flags cleared at once");
  sw_end_hold_a: assert property (sw_end_irq_o && !(reg_wr_i &&
    reg_addr_i == TCC_MODE_B_OFS && !reg_wdata_i[6]) |=> sw_end_irq_o)
    else $error("software end interrupt dropped");
  addr_hold_a: assert property (!(xfer_req_o && xfer_done_i) &&
    !reg_wr_i |=> $stable(xfer_src_addr_o) && $stable(xfer_dst_addr_o))
    else $error("address moved without an item");
  vec_read_a: assert property (reg_rd_i && reg_addr_i == TCC_SW_VEC_OFS
    |=> reg_rdata_o[6:0] == $past(vec_num) && reg_rdata_o[31:8] == 24'h0)
    else $error("vector read disagrees with vector address");
endmodule : tcc_core_props

bind tcc_core tcc_core_props #(.NSRC(NSRC)) u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i),
  .cpu_req_o(cpu_req_o), .src_clear_o(src_clear_o),
  .sw_end_irq_o(sw_end_irq_o), .xfer_req_o(xfer_req_o),
  .xfer_src_addr_o(xfer_src_addr_o), .xfer_dst_addr_o(xfer_dst_addr_o),
  .xfer_done_i(xfer_done_i), .busy_o(busy_o),
  .sw_vector_addr_o(sw_vector_addr_o));

/* tcc_core_bench.sv */
`timescale 1ns/1ps
module tcc_core_bench
  import tcc_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [63:0] raise = '0;
  logic [3:0] dly = 4'h0;
  logic [31:0] reg_rdata_o;
  logic [63:0] src_req_i, cpu_req_o, src_clear_o;
  logic sw_end_irq_o, xfer_req_o, xfer_word_o, xfer_done_i;
  logic busy_o, active_sw_o;
  logic [23:0] xfer_src_addr_o, xfer_dst_addr_o;
  logic [5:0] active_src_o;
  logic [15:0] sw_vector_addr_o;
  int miscompares = 0;
  int n_compared = 0;

  // 10 MHz system clock
  always #50 clk_i = ~clk_i;

  tcc_core dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i),
    .cpu_req_o(cpu_req_o), .src_clear_o(src_clear_o),
    .sw_end_irq_o(sw_end_irq_o), .xfer_req_o(xfer_req_o),
    .xfer_src_addr_o(xfer_src_addr_o), .xfer_dst_addr_o(xfer_dst_addr_o),
    .xfer_word_o(xfer_word_o), .xfer_done_i(xfer_done_i),
    .busy_o(busy_o), .active_sw_o(active_sw_o),
    .active_src_o(active_src_o), .sw_vector_addr_o(sw_vector_addr_o));
  tcc_engine_model u_eng (.clk_i(clk_i), .resetn_i(resetn_i),
    .raise_i(raise), .dly_i(dly), .xfer_req_i(xfer_req_o),
    .clear_i(src_clear_o), .flag_o(src_req_i), .done_o(xfer_done_i));

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk($sformatf("reg %h", a), e, reg_rdata_o);
  endtask : rd

  // Even addresses only, as word items demand
  task automatic cfg(logic [23:0] s, d, logic [15:0] ca, cb,
                     logic [7:0] ma, mb);
    wr(8'h00, {8'h0, s});
    wr(8'h04, {8'h0, d});
    wr(8'h08, {16'h0, ca});
    wr(8'h0c, {16'h0, cb});
    wr(8'h10, {24'h0, ma});
    wr(8'h14, {24'h0, mb});
  endtask : cfg

  task automatic fire(logic [63:0] m);
    @(posedge clk_i);
    raise <= m;
    @(posedge clk_i);
    raise <= '0;
    @(negedge clk_i);
    chk("cpu_req", 0, {31'h0, |(cpu_req_o & m)});
  endtask : fire

  // Bounded wait for one activation to start and finish
  task automatic go;
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk("start", 1, {31'h0, busy_o === 1'b1});
    while (busy_o !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk("busy", 1, {31'h0, n < 200});
  endtask : go

  task automatic t_normal;
    cfg(24'h100, 24'h200, 16'h2, 16'h0, 8'ha1, 8'h00);
    wr(8'h20, 32'h08);
    fire(64'h8);
    go();
    chk("word", 1, {31'h0, xfer_word_o});
    chk("xsrc", 32'h102, {8'h0, xfer_src_addr_o});
    rd(8'h00, 32'h102);
    rd(8'h04, 32'h202);
    rd(8'h08, 32'h1);
    rd(8'h20, 32'h08);
    chk("flag3", 0, {31'h0, src_req_i[3]});
    fire(64'h8);
    go();
    rd(8'h08, 32'h0);
    rd(8'h20, 32'h0);
    chk("cpu3", 1, {31'h0, cpu_req_o[3]});
  endtask : t_normal

  task automatic t_repeat;
    dly <= 4'h3;
    cfg(24'h300, 24'h400, 16'h0201, 16'h0, 8'h04, 8'h00);
    wr(8'h24, 32'h01);
    fire(64'h100);
    go();
    chk("word", 0, {31'h0, xfer_word_o});
    rd(8'h08, 32'h0202);
    rd(8'h00, 32'h300);
    rd(8'h24, 32'h01);
    dly <= 4'h0;
  endtask : t_repeat

  task automatic t_block;
    cfg(24'h0, 24'h500, 16'h0202, 16'h2, 8'h28, 8'h00);
    wr(8'h28, 32'h01);
    fire(64'h1_0000);
    go();
    rd(8'h08, 32'h0202);
    rd(8'h0c, 32'h1);
    rd(8'h04, 32'h502);
    rd(8'h28, 32'h01);
    fire(64'h1_0000);
    go();
    rd(8'h0c, 32'h0);
    rd(8'h28, 32'h0);
  endtask : t_block

  task automatic t_soft;
    cfg(24'h0, 24'h0, 16'h3, 16'h0, 8'h00, 8'h00);
    wr(8'h18, 32'h90);
    go();
    chk("vaddr", 32'h0420, {16'h0, sw_vector_addr_o});
    chk("actsw", 1, {31'h0, active_sw_o});
    rd(8'h18, 32'h10);
    rd(8'h08, 32'h2);
    wr(8'h14, 32'h40);
    wr(8'h18, 32'h85);
    go();
    rd(8'h18, 32'h85);
    chk("swend", 1, {31'h0, sw_end_irq_o});
    rd(8'h1c, 32'h2);
    wr(8'h18, 32'h07);
    rd(8'h18, 32'h85);
    repeat (4) @(negedge clk_i);
    chk("rerun", 0, {31'h0, busy_o});
    wr(8'h14, 32'h00);
    rd(8'h18, 32'h05);
    chk("swend", 0, {31'h0, sw_end_irq_o});
    chk("vaddr", 32'h040a, {16'h0, sw_vector_addr_o});
  endtask : t_soft

  task automatic t_prio;
    cfg(24'h0, 24'h0, 16'h5, 16'h0, 8'h00, 8'h40);
    wr(8'h20, 32'h06);
    fire(64'h6);
    @(negedge clk_i);
    chk("first", 1, {26'h0, active_src_o});
    go();
    go();
    rd(8'h08, 32'h3);
    rd(8'h20, 32'h0);
  endtask : t_prio

  // Chained items keep flag and enable, so the source fires again
  task automatic t_chain;
    cfg(24'h0, 24'h0, 16'h1, 16'h0, 8'h00, 8'h80);
    wr(8'h20, 32'h10);
    fire(64'h10);
    go();
    rd(8'h20, 32'h10);
    chk("flag4", 1, {31'h0, src_req_i[4]});
    wr(8'h20, 32'h00);
    repeat (8) @(negedge clk_i);
    chk("busy", 0, {31'h0, busy_o});
    chk("cpu4", 1, {31'h0, cpu_req_o[4]});
  endtask : t_chain

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h20, 32'h0);
    rd(8'h18, 32'h0);
    chk("vaddr", 32'h0400, {16'h0, sw_vector_addr_o});
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    t_normal();
    t_repeat();
    t_block();
    t_soft();
    t_prio();
    t_chain();
    report_and_stop();
  end

  // Watchdog, well past the expected run length
  initial begin
    #(5000 * 100);
    miscompares++;
    report_and_stop();
  end
endmodule : tcc_core_bench
